//--- core/watchdog_and_reset_cause.sv
// watchdog control and reset-cause register of the reset unit
// assumes sfr accesses come from the core on clk_sys; rst is the power-on reset
// assumes the reset unit outside holds the system reset and pulses sys_reset_done
// Contract
// [R1] timeout is four to the power of three plus interval, in clocks
// [R2] software keeps bit 7 zero when writing a new interval
// [R3] reading watchdog control returns the interval in bits 2..0
// [R4] interval reads 111b after any system reset
// [R5] writing a5 enables the watchdog and restarts its count
// [R6] de then ad within 4 clocks disables; longer gap ignored
// [R7] writing ff sets a lock refusing every later disable
// [R8] bit 4 reads 1 while watchdog active, 0 while inactive
// [R9] watchdog control at ff on all pages, reset cause at ef page 0
// [R10] bit 6 enables low convert-start input as reset; reads its flag
// [R11] bit 5 enables low comparator output as reset; reads its flag
// [R12] writing 1 to bit 4 forces internal reset, pin untouched
// [R13] bit 4 reads 1 after a software-forced reset
// [R14] bit 3 read-only, 1 after a watchdog timeout reset
// [R15] bit 2 enables missing-clock reset; reads its flag
// [R16] with monitor pin high, bit 1 selects supply monitor as source
// [R17] bit 1 reads 1 after power-on or monitor reset
// [R18] writing 1 to bit 0 forces power-on reset, pin driven low
// [R19] bit 0 reads 1 after an external pin reset
// [R20] bit 7 reserved, reads zero
// [R21] lock holds until next system reset
// [R22] lock command neither enables nor restarts the watchdog
// [R23] every system reset leaves watchdog enabled, count restarted
// [R24] watchdog expiry enters reset without driving the pin
// [R25] each reset sets its own flag, clears others; enables kept apart
// [R26] software locks early and masks interrupts around disable pair
`timescale 1ns/1ps
module watchdog_and_reset_cause
   import wdog_pkg::*;
#(
   parameter int CNT_W = WDT_CNT_W
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // system reset sequencing
   input  wire logic       sys_reset_active,
   input  wire logic       sys_reset_done,
   input  wire logic       ext_pin_reset_n,
   // sfr access
   input  wire sfr_req_t   sfr,
   output logic [7:0]      sfr_rdata,
   output logic            sfr_rvalid,
   // reset sources
   input  wire src_in_t    src,
   // reset requests
   output logic            internal_reset_req,
   output logic            power_on_reset_req,
   output logic            pin_drive_low,
   output logic            supply_monitor_select
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      // watchdog
      logic             wdt_on;
      logic             locked;
      logic [2:0]       interval;
      logic [CNT_W-1:0] count;
      // disable window
      logic             armed;
      logic [2:0]       gap;
      // reset cause
      logic [6:0]       flags;
      logic             en_convert;
      logic             en_comp;
      logic             en_mcd;
      logic             sel_monitor;
      cause_t           cause;
      logic             cause_valid;
      // read port
      logic [7:0]       rdata;
      logic             rvalid;
      // requests
      logic             int_req;
      logic             por_req;
      logic             pin_low;
      // input synchronisers
      logic [1:0]       conv_sync;
      logic [1:0]       comp_sync;
      logic [1:0]       mcd_sync;
      logic [1:0]       mon_sync;
      logic [1:0]       pin_sync;
   } state_t;

   state_t st;
   state_t next_st;

   // ************************************************************
   // functions
   // ************************************************************

   // four to the power (3 + interval) clocks, minus one for a zero-based count
   // interval 7 needs 20 bits of the count, so CNT_W must not shrink below 20
   function automatic logic [CNT_W-1:0] limit_of(input logic [2:0] iv);
      logic [5:0] sh;
      sh = 6'(2 * (INTERVAL_BASE + int'(iv)));
      return CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << sh) - 1'b1);
   endfunction : limit_of

   // the control byte answers on every page, the cause byte on one page only
   function automatic logic sfr_hit(input sfr_req_t req, input logic [7:0] at,
                                    input logic paged);
      logic page_ok;
      page_ok = !paged || req.page == PAGE_RESET_CAUSE;
      return req.addr == at && page_ok;
   endfunction : sfr_hit

   // a source fires only while enabled and at its active level
   function automatic logic src_fires(input logic en, input logic lvl, input logic act_hi);
      return en && lvl == act_hi;
   endfunction : src_fires

   // ************************************************************
   // address decode
   // ************************************************************

   logic wr_wdc;
   logic wr_rc;
   logic rd_wdc;
   logic rd_rc;
   assign wr_wdc = sfr.wr && sfr_hit(sfr, ADDR_WATCHDOG_CONTROL, 1'b0);      // see [R9]
   assign rd_wdc = sfr.rd && sfr_hit(sfr, ADDR_WATCHDOG_CONTROL, 1'b0);      // see [R9]
   assign wr_rc  = sfr.wr && sfr_hit(sfr, ADDR_RESET_CAUSE, 1'b1);           // see [R9]
   assign rd_rc  = sfr.rd && sfr_hit(sfr, ADDR_RESET_CAUSE, 1'b1);           // see [R9]

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;

      // ************************************************************
      // synchronisers: two flops on every pin-level input
      // ************************************************************
      next_st.conv_sync = {st.conv_sync[0], src.convert_start_input};
      next_st.comp_sync = {st.comp_sync[0], src.comparator_zero_output};
      next_st.mcd_sync  = {st.mcd_sync[0], src.missing_clock_timeout};
      next_st.mon_sync  = {st.mon_sync[0], src.supply_monitor_enable_pin};
      next_st.pin_sync  = {st.pin_sync[0], ext_pin_reset_n};
      next_st.rvalid    = 1'b0;

      // ************************************************************
      // system reset hold
      // ************************************************************
      if (sys_reset_active) begin
         // while held in reset the watchdog restarts and the lock falls away
         next_st.wdt_on   = 1'b1;                                            // see [R23]
         next_st.count    = '0;                                              // see [R23]
         next_st.locked   = 1'b0;                                            // see [R21]
         next_st.interval = INTERVAL_RESET;                                  // see [R4]
         next_st.armed    = 1'b0;
         next_st.int_req  = 1'b0;
         next_st.por_req  = 1'b0;
         next_st.pin_low  = st.por_req;                                      // see [R18]
         // a pin reset is only known as the cause if nothing internal asked first
         if (!st.cause_valid && !st.pin_sync[1]) begin
            next_st.cause       = CAUSE_PIN;
            next_st.cause_valid = 1'b1;
         end
      end else begin
         next_st.pin_low = 1'b0;
         // ************************************************************
         // disable window: closes after the allowed gap
         // ************************************************************
         if (st.armed) begin
            next_st.gap = st.gap + 3'h1;
            if (int'(st.gap) >= DISABLE_GAP - 1) begin
               next_st.armed = 1'b0;                                         // see [R6]
            end
         end

         // ************************************************************
         // watchdog count
         // ************************************************************
         // the count parks at its limit so the request stands until reset
         if (st.wdt_on) begin
            if (st.count >= limit_of(st.interval)) begin
               // expiry is an internal reset only, the pin stays quiet
               next_st.int_req     = 1'b1;                                   // see [R24]
               next_st.cause       = CAUSE_WDT;                              // see [R1]
               next_st.cause_valid = 1'b1;
            end else begin
               next_st.count = st.count + 1'b1;                              // see [R1]
            end
         end

         // ************************************************************
         // watchdog control writes
         // ************************************************************
         if (wr_wdc) begin
            // any control write ends a pending disable pair
            next_st.armed = 1'b0;
            unique case (sfr.wdata)
               CMD_RELOAD: begin
                  next_st.wdt_on = 1'b1;                                     // see [R5]
                  next_st.count  = '0;                                       // see [R5]
               end
               CMD_DISABLE_1: begin
                  next_st.armed = 1'b1;
                  next_st.gap   = 3'h0;
               end
               CMD_DISABLE_2: begin
                  if (st.armed && !st.locked) begin
                     next_st.wdt_on = 1'b0;                                  // see [R6]
                  end
               end
               CMD_LOCK: begin
                  next_st.locked = 1'b1;                                     // see [R7] [R22]
               end
               default: begin
                  if (!sfr.wdata[WDC_CMD_BIT]) begin
                     next_st.interval = sfr.wdata[WDC_INT_LSB +: WDC_INT_W]; // see [R2]
                  end
               end
            endcase
         end

         // ************************************************************
         // reset-cause writes
         // ************************************************************
         // a forced reset is recorded at once; the outer unit acts on the request
         if (wr_rc) begin
            // enables live apart from the flags that reads return
            next_st.en_convert = sfr.wdata[RC_CONVERT];                      // see [R10] [R25]
            next_st.en_comp    = sfr.wdata[RC_COMP];                         // see [R11]
            next_st.en_mcd     = sfr.wdata[RC_MCD];                          // see [R15]
            if (st.mon_sync[1]) begin
               next_st.sel_monitor = sfr.wdata[RC_POR];                      // see [R16]
            end
            if (sfr.wdata[RC_SW]) begin
               next_st.int_req     = 1'b1;                                   // see [R12]
               next_st.cause       = CAUSE_SW;
               next_st.cause_valid = 1'b1;
            end
            if (sfr.wdata[RC_PIN]) begin
               next_st.por_req     = 1'b1;                                   // see [R18]
               next_st.cause       = CAUSE_POR;
               next_st.cause_valid = 1'b1;
            end
         end

         // ************************************************************
         // source monitoring
         // ************************************************************
         // levels, not edges: a source held active keeps asking
         if (src_fires(st.en_convert, st.conv_sync[1], 1'b0)) begin
            next_st.int_req = 1'b1;                                          // see [R10]
            next_st.cause   = CAUSE_CONVERT;
            next_st.cause_valid = 1'b1;
         end
         if (src_fires(st.en_comp, st.comp_sync[1], 1'b0)) begin
            next_st.int_req = 1'b1;                                          // see [R11]
            next_st.cause   = CAUSE_COMP;
            next_st.cause_valid = 1'b1;
         end
         if (src_fires(st.en_mcd, st.mcd_sync[1], 1'b1)) begin
            next_st.int_req = 1'b1;                                          // see [R15]
            next_st.cause   = CAUSE_MCD;
            next_st.cause_valid = 1'b1;
         end
      end

      // ************************************************************
      // cause latch
      // ************************************************************
      // at the end of a reset the single cause flag replaces all the others
      if (sys_reset_done && st.cause_valid) begin
         next_st.flags       = '0;                                           // see [R25]
         next_st.cause_valid = 1'b0;
         unique case (st.cause)
            CAUSE_POR: begin
               next_st.flags[RC_POR] = 1'b1;                                 // see [R17]
            end
            CAUSE_PIN: begin
               next_st.flags[RC_PIN] = 1'b1;                                 // see [R19]
            end
            CAUSE_CONVERT: begin
               next_st.flags[RC_CONVERT] = 1'b1;                             // see [R10]
            end
            CAUSE_COMP: begin
               next_st.flags[RC_COMP] = 1'b1;                                // see [R11]
            end
            CAUSE_SW: begin
               next_st.flags[RC_SW] = 1'b1;                                  // see [R13]
            end
            CAUSE_WDT: begin
               next_st.flags[RC_WDT] = 1'b1;                                 // see [R14]
            end
            CAUSE_MCD: begin
               next_st.flags[RC_MCD] = 1'b1;                                 // see [R15]
            end
         endcase
      end

      // ************************************************************
      // read path
      // ************************************************************
      // read data holds until the next read; only the valid pulse drops
      if (rd_wdc) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = 8'h00;
         next_st.rdata[WDC_STATUS_BIT] = st.wdt_on;                          // see [R8]
         next_st.rdata[WDC_INT_LSB +: WDC_INT_W] = st.interval;              // see [R3]
      end else if (rd_rc) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = {1'b0, st.flags};                                  // see [R20]
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st             <= '0;
         st.wdt_on      <= 1'b1;
         st.interval    <= INTERVAL_RESET;
         st.flags       <= RESET_CAUSE_RESET[6:0];
         st.cause       <= CAUSE_POR;
         st.cause_valid <= 1'b1;
         st.conv_sync   <= 2'h3;
         st.comp_sync   <= 2'h3;
         st.pin_sync    <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   // read port
   assign sfr_rdata             = st.rdata;
   assign sfr_rvalid            = st.rvalid;
   // reset requests
   assign internal_reset_req    = st.int_req;
   assign power_on_reset_req    = st.por_req;
   assign pin_drive_low         = st.pin_low;
   assign supply_monitor_select = st.sel_monitor;

endmodule : watchdog_and_reset_cause

//--- shared/wdog_pkg.sv
// constants and carrier types for the watchdog and reset-cause unit
// assumes a single system clock domain and an sfr-style byte access port
package wdog_pkg;
   // ************************************************************
   // register addresses and page
   // ************************************************************
   localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hff;
   localparam logic [7:0] ADDR_RESET_CAUSE      = 8'hef;
   localparam logic [7:0] PAGE_RESET_CAUSE      = 8'h00;

   // ************************************************************
   // watchdog command codes and field positions
   // ************************************************************
   localparam logic [7:0] CMD_RELOAD     = 8'ha5;
   localparam logic [7:0] CMD_DISABLE_1  = 8'hde;
   localparam logic [7:0] CMD_DISABLE_2  = 8'had;
   localparam logic [7:0] CMD_LOCK       = 8'hff;
   localparam int         WDC_CMD_BIT    = 7;
   localparam int         WDC_STATUS_BIT = 4;
   localparam int         WDC_INT_LSB    = 0;
   localparam int         WDC_INT_W      = 3;
   localparam logic [2:0] INTERVAL_RESET = 3'h7;
   localparam int         INTERVAL_BASE  = 3;
   localparam int         DISABLE_GAP    = 4;
   localparam int         WDT_CNT_W      = 21;

   // ************************************************************
   // reset-cause bit positions
   // ************************************************************
   localparam int         RC_CONVERT = 6;
   localparam int         RC_COMP    = 5;
   localparam int         RC_SW      = 4;
   localparam int         RC_WDT     = 3;
   localparam int         RC_MCD     = 2;
   localparam int         RC_POR     = 1;
   localparam int         RC_PIN     = 0;
   localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;

   // cause of the reset that is being entered
   typedef enum logic [2:0] {
      CAUSE_POR, CAUSE_PIN, CAUSE_CONVERT, CAUSE_COMP, CAUSE_SW, CAUSE_WDT, CAUSE_MCD
   } cause_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] page;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic       convert_start_input;
      logic       comparator_zero_output;
      logic       missing_clock_timeout;
      logic       supply_monitor_enable_pin;
   } src_in_t;
endpackage : wdog_pkg

//--- verification/tb.sv
// self-checking bench for the watchdog and reset-cause unit
// assumes the checker binds itself; one 25 MHz clock
`timescale 1ns/1ps
module tb
   import wdog_pkg::*;
();
   localparam logic [7:0] W  = ADDR_WATCHDOG_CONTROL;
   localparam logic [7:0] R  = ADDR_RESET_CAUSE;
   localparam logic [7:0] ON = 8'h01 << WDC_STATUS_BIT;
   localparam logic [7:0] DF = ON | {5'h00, INTERVAL_RESET};
   logic       clk_sys;
   logic       rst = 1'b1;
   logic       act = 1'b0;
   logic       done = 1'b0;
   logic       pin_n = 1'b1;
   sfr_req_t   sfr = '0;
   src_in_t    src = 4'b1100;
   logic [7:0] rdata;
   logic       rvalid, ireq, preq, pdl, msel, low_seen;
   int         bad_count = 0;
   int         n_tests = 0;
   int         c;

   watchdog_and_reset_cause dut (
      .clk_sys(clk_sys), .rst(rst), .sys_reset_active(act), .sys_reset_done(done),
      .ext_pin_reset_n(pin_n), .sfr(sfr), .sfr_rdata(rdata), .sfr_rvalid(rvalid), .src(src),
      .internal_reset_req(ireq), .power_on_reset_req(preq), .pin_drive_low(pdl),
      .supply_monitor_select(msel)
   );

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ****
   // helpers
   // ****
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // strobes stay up until the next helper, so no signal is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, page: 8'h00, wdata: d};
      tick(1);
   endtask : wr

   task automatic idle(input int n);
      sfr = '0;
      tick(n);
   endtask : idle

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] pg,
                     input logic ev, input logic [7:0] exp);
      sfr = '{wr: 1'b0, rd: 1'b1, addr: a, page: pg, wdata: 8'h00};
      tick(1);
      chk({what, " valid"}, {7'h00, ev}, {7'h00, rvalid});
      if (ev) chk(what, exp, rdata);
   endtask : rd

   task automatic sysrst();
      sfr = '0;
      act = 1'b1;
      low_seen = 1'b0;
      repeat (4) begin
         tick(1);
         low_seen |= pdl;
      end
      pin_n = 1'b1;
      act = 1'b0;
      done = 1'b1;
      tick(1);
      done = 1'b0;
      tick(2);
   endtask : sysrst

   task automatic wait_req();
      sfr = '0;
      c = 0;
      while (ireq !== 1'b1) begin
         if (c == 5000) begin
            bad_count++;
            end_of_test();
         end
         tick(1);
         c++;
      end
   endtask : wait_req

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ****
   // scenarios
   // ****
   task automatic t_regs();
      rd("control", W, 8'h00, 1'b1, DF);
      rd("control page 5", W, 8'h05, 1'b1, DF);
      rd("cause", R, 8'h00, 1'b1, 8'h01 << RC_POR);
      rd("cause page 1", R, 8'h01, 1'b0, 8'h00);
      rd("unmapped", 8'h80, 8'h00, 1'b0, 8'h00);
   endtask : t_regs

   task automatic t_wdog();
      wr(W, 8'h02);
      rd("interval", W, 8'h00, 1'b1, ON | 8'h02);
      wr(W, 8'h85);
      rd("bit7 write", W, 8'h00, 1'b1, ON | 8'h02);
      wr(W, CMD_DISABLE_1);
      idle(3);
      wr(W, CMD_DISABLE_2);
      rd("gap 4 disable", W, 8'h00, 1'b1, 8'h02);
      wr(W, CMD_RELOAD);
      rd("reload", W, 8'h00, 1'b1, ON | 8'h02);
      wr(W, CMD_DISABLE_1);
      idle(4);
      wr(W, CMD_DISABLE_2);
      rd("gap 5 disable", W, 8'h00, 1'b1, ON | 8'h02);
      wr(W, CMD_DISABLE_1);
      wr(W, CMD_DISABLE_2);
      wr(W, CMD_LOCK);
      rd("lock when off", W, 8'h00, 1'b1, 8'h02);
      wr(W, CMD_RELOAD);
      wr(W, CMD_DISABLE_1);
      wr(W, CMD_DISABLE_2);
      rd("locked disable", W, 8'h00, 1'b1, ON | 8'h02);
   endtask : t_wdog

   task automatic t_expiry();
      wr(W, 8'h00);
      wr(W, CMD_RELOAD);
      wait_req();
      chk("expiry cycles", 8'(4 ** INTERVAL_BASE), c[7:0]);
      sysrst();
      chk("pin on expiry", 8'h00, {7'h00, low_seen});
      rd("cause", R, 8'h00, 1'b1, 8'h01 << RC_WDT);
      rd("control", W, 8'h00, 1'b1, DF);
      wr(W, CMD_DISABLE_1);
      wr(W, CMD_DISABLE_2);
      rd("unlocked", W, 8'h00, 1'b1, 8'h07);
   endtask : t_expiry

   task automatic t_force();
      wr(R, 8'h01 << RC_SW);
      idle(1);
      chk("soft req", 8'h01, {7'h00, ireq});
      sysrst();
      chk("soft pin", 8'h00, {7'h00, low_seen});
      rd("cause", R, 8'h00, 1'b1, 8'h01 << RC_SW);
      wr(R, 8'h01 << RC_PIN);
      idle(1);
      chk("por req", 8'h01, {7'h00, preq});
      sysrst();
      chk("por pin", 8'h01, {7'h00, low_seen});
      rd("cause", R, 8'h00, 1'b1, 8'h01 << RC_POR);
      pin_n = 1'b0;
      tick(3);
      sysrst();
      rd("cause", R, 8'h00, 1'b1, 8'h01 << RC_PIN);
   endtask : t_force

   task automatic t_sources();
      int pos[3] = '{RC_CONVERT, RC_COMP, RC_MCD};
      for (int i = 0; i < 3; i++) begin
         src = src ^ (4'h8 >> i);
         idle(6);
         chk("masked source", 8'h00, {7'h00, ireq});
         wr(R, 8'h01 << pos[i]);
         wait_req();
         chk("source delay", 8'h01, {7'h00, c < 8});
         src = src ^ (4'h8 >> i);
         sysrst();
         rd("source cause", R, 8'h00, 1'b1, 8'h01 << pos[i]);
      end
   endtask : t_sources

   task automatic t_monitor();
      for (int i = 0; i < 2; i++) begin
         src.supply_monitor_enable_pin = i[0];
         idle(4);
         wr(R, 8'h01 << RC_POR);
         idle(1);
         chk("monitor select", {7'h00, i[0]}, {7'h00, msel});
         wr(R, 8'h00);
         idle(1);
         chk("monitor drop", 8'h00, {7'h00, msel});
      end
   endtask : t_monitor

   initial begin
      tick(5);
      rst = 1'b0;
      sysrst();
      t_regs();
      t_wdog();
      t_expiry();
      t_force();
      t_sources();
      t_monitor();
      end_of_test();
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      end_of_test();
   end
endmodule : tb

//--- verification/wdog_rc_assertions.sv
// port-level checks for the watchdog and reset-cause unit
// assumes one clock domain; bound to every instance of the unit
`timescale 1ns/1ps
module wdog_rc_assertions
   import wdog_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sys_reset_active,
   // register access
   input wire sfr_req_t   sfr,
   input wire logic [7:0] sfr_rdata,
   input wire logic       sfr_rvalid,
   // sources and requests
   input wire src_in_t    src,
   input wire logic       internal_reset_req,
   input wire logic       power_on_reset_req,
   input wire logic       pin_drive_low,
   input wire logic       supply_monitor_select
);
   // ****
   // decoding
   // ****
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire rc_sel  = sfr.addr == ADDR_RESET_CAUSE;
   wire wr_rc   = sfr.wr && rc_sel && sfr.page == PAGE_RESET_CAUSE && !sys_reset_active;
   wire off_rd  = sfr.rd && rc_sel && sfr.page != PAGE_RESET_CAUSE;
   wire soft_wr = wr_rc && sfr.wdata[RC_SW] && !sfr.wdata[RC_PIN] && !power_on_reset_req
                  && !pin_drive_low;
   sequence rd_wdc;
      sfr.rd && sfr.addr == ADDR_WATCHDOG_CONTROL && !sys_reset_active;
   endsequence
   sequence rd_rc;
      sfr.rd && rc_sel && sfr.page == PAGE_RESET_CAUSE && !sys_reset_active;
   endsequence
   sequence answered(logic [7:0] zero_mask);
      sfr_rvalid && (sfr_rdata & zero_mask) == 8'h00;
   endsequence
   // the monitor pin passes a synchroniser, so only a settled level counts
   sequence mon_wr(logic lvl);
      wr_rc && src.supply_monitor_enable_pin == lvl
      && $past(src.supply_monitor_enable_pin, 2) == lvl;
   endsequence
   // ****
   // properties
   // ****
   wdc_read_answer_a: assert property (rd_wdc |=> answered(8'he8))
      else $error("control read bad");
   rc_read_answer_a: assert property (rd_rc |=> answered(8'h80))
      else $error("cause read bad");
   rc_page_guard_a: assert property (off_rd |=> !sfr_rvalid)
      else $error("cause answered off page");
   sw_force_req_a: assert property (wr_rc && sfr.wdata[RC_SW] |=> internal_reset_req)
      else $error("soft reset not requested");
   sw_pin_quiet_a: assert property (soft_wr |=> !pin_drive_low)
      else $error("pin driven by soft reset");
   por_force_req_a: assert property (wr_rc && sfr.wdata[RC_PIN] |=> power_on_reset_req)
      else $error("power-on force not requested");
   req_holds_a: assert property (internal_reset_req && !sys_reset_active |=> internal_reset_req)
      else $error("reset request dropped early");
   mon_select_a: assert property (mon_wr(1'b1) |=> supply_monitor_select == $past(sfr.wdata[RC_POR]))
      else $error("monitor select not taken");
   mon_ignored_a: assert property (mon_wr(1'b0) |=> $stable(supply_monitor_select))
      else $error("monitor select changed with pin low");
endmodule : wdog_rc_assertions

bind watchdog_and_reset_cause wdog_rc_assertions chk_i (
   .clk_sys(clk_sys), .rst(rst), .sys_reset_active(sys_reset_active), .sfr(sfr),
   .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .src(src),
   .internal_reset_req(internal_reset_req), .power_on_reset_req(power_on_reset_req),
   .pin_drive_low(pin_drive_low), .supply_monitor_select(supply_monitor_select)
);
